// File: hdl/dlcc_loop_config.sv
// Loop control configuration bank for the first loop: registers, decode, refresh tick
// Behaviour
// - Requalify time is 2/4/16/32 times drop time
// - Drop time comes from four-bit drop code
// - Realign bit 0: build out phase on switch
// - Realign bit 1: realign to new reference phase
// - Realign resets 0 only if strap high, secondary low
// - Bandwidth codes, fast lock, 111 hands over
// - 28 Hz limited for 2 kHz refs, 890 Hz for 2 kHz/8 kHz refs
// - Bandwidth resets 110 primary, 101 secondary
// - Slew cap codes; 11 unlimited is reset
// - Extended width 0.3/1.0/3.0, 1.0 reset
// - Extended width used only when bandwidth 111
// - Revertive bit, resets to zero
// - Holdover refresh 26ms/1s/10s/60s, reset 26ms
// - Post filter bypass/18/0.6/10 selection
// - Post filter resets 00 primary, 01 secondary
module dlcc_loop_config
   import dlcc_pkg::*;
#(
   parameter longint HREF0_CYC = DLCC_HREF0_CYC,
   parameter longint HREF1_CYC = DLCC_HREF1_CYC,
   parameter longint HREF2_CYC = DLCC_HREF2_CYC,
   parameter longint HREF3_CYC = DLCC_HREF3_CYC
) (
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       buildout_strap_pin,
   input  wire logic       secondary_role_pin,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       ref_is_2khz,
   input  wire logic       ref_is_8khz,
   input  wire logic       ref_switch,
   output logic            buildout_pulse,
   output logic            realign_pulse,
   output logic            holdover_tick,
   output dlcc_cfg_t       loop_cfg
);

   logic [7:0]             qual_reg;
   logic [7:0]             ctrl0_reg;
   logic [7:0]             ctrl1_reg;
   logic [7:0]             rd_data_next;
   dlcc_cfg_t              cfg_next;
   logic [DLCC_HCNT_W-1:0] hcnt_reg;
   logic [DLCC_HCNT_W-1:0] hlimit;

   // Straps are sampled while the synchronous reset is held
   always_ff @(posedge mclk) begin
      if (srst) begin
         qual_reg <= DLCC_QUAL_RST;
      end else if (wr_en && addr == DLCC_QUAL_OFS) begin
         qual_reg <= wr_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl0_reg[DLCC_REALIGN_BIT] <= ~(buildout_strap_pin & ~secondary_role_pin);
         ctrl0_reg[DLCC_BW_LSB +: 3] <= secondary_role_pin ? DLCC_BW_RST_SEC
                                                           : DLCC_BW_RST_PRI;
         ctrl0_reg[DLCC_SLEW_LSB +: 2] <= DLCC_SLEW_RST;
         ctrl0_reg[DLCC_S3E_LSB +: 2]  <= DLCC_S3E_RST;
      end else if (wr_en && addr == DLCC_CTRL0_OFS) begin
         ctrl0_reg <= wr_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl1_reg                     <= DLCC_CTRL1_FIX_RST;
         ctrl1_reg[DLCC_PFILT_LSB +: 2] <= secondary_role_pin ? DLCC_PFILT_RST_SEC
                                                              : DLCC_PFILT_RST_PRI;
      end else if (wr_en && addr == DLCC_CTRL1_OFS) begin
         ctrl1_reg <= wr_data;
      end
   end

   // Read data stand only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      rd_data_next = 8'h00;
      if (rd_en) begin
         case (addr)
            DLCC_QUAL_OFS:  rd_data_next = qual_reg;
            DLCC_CTRL0_OFS: rd_data_next = ctrl0_reg;
            DLCC_CTRL1_OFS: rd_data_next = ctrl1_reg;
            default:        rd_data_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_data_next;
      end
   end

   // Decode of the register fields into what the loop consumes
   always_comb begin
      cfg_next.drop_delay_code   = qual_reg[DLCC_DROP_LSB +: 4];
      case (qual_reg[DLCC_REQUAL_LSB +: 2])
         2'h0:    cfg_next.requalify_factor = 6'h02;
         2'h1:    cfg_next.requalify_factor = 6'h04;
         2'h2:    cfg_next.requalify_factor = 6'h10;
         default: cfg_next.requalify_factor = 6'h20;
      endcase
      cfg_next.realign_on_switch = ctrl0_reg[DLCC_REALIGN_BIT];
      case (ctrl0_reg[DLCC_BW_LSB +: 3])
         3'h0:    cfg_next.loop_width = DLCC_LW_0P1HZ;
         3'h1:    cfg_next.loop_width = DLCC_LW_1P7HZ;
         3'h2:    cfg_next.loop_width = DLCC_LW_3P5HZ;
         3'h3:    cfg_next.loop_width = DLCC_LW_14HZ;
         3'h4:    cfg_next.loop_width = ref_is_2khz ? DLCC_LW_14HZ : DLCC_LW_28HZ;
         3'h5: begin
            if (ref_is_2khz) begin
               cfg_next.loop_width = DLCC_LW_14HZ;
            end else if (ref_is_8khz) begin
               cfg_next.loop_width = DLCC_LW_56HZ;
            end else begin
               cfg_next.loop_width = DLCC_LW_890HZ;
            end
         end
         3'h6:    cfg_next.loop_width = DLCC_LW_FAST7;
         default: begin
            // Reserved extended code falls back to the middle setting
            case (ctrl0_reg[DLCC_S3E_LSB +: 2])
               2'h0:    cfg_next.loop_width = DLCC_LW_EXT0P3;
               2'h2:    cfg_next.loop_width = DLCC_LW_EXT3P0;
               default: cfg_next.loop_width = DLCC_LW_EXT1P0;
            endcase
         end
      endcase
      cfg_next.phase_slew_cap       = ctrl0_reg[DLCC_SLEW_LSB +: 2];
      cfg_next.revertive            = ctrl1_reg[DLCC_REVERT_BIT];
      cfg_next.holdover_refresh     = ctrl1_reg[DLCC_HREF_LSB +: 2];
      cfg_next.holdover_post_filter = ctrl1_reg[DLCC_PFILT_LSB +: 2];
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         loop_cfg <= '0;
      end else begin
         loop_cfg <= cfg_next;
      end
   end

   // On a reference switch tell the loop which way to treat the phase step
   always_ff @(posedge mclk) begin
      if (srst) begin
         buildout_pulse <= 1'b0;
         realign_pulse  <= 1'b0;
      end else begin
         buildout_pulse <= ref_switch & ~ctrl0_reg[DLCC_REALIGN_BIT];
         realign_pulse  <= ref_switch & ctrl0_reg[DLCC_REALIGN_BIT];
      end
   end

   // Holdover refresh tick; a shorter interval written once the count has passed it ends the count at once
   always_comb begin
      case (ctrl1_reg[DLCC_HREF_LSB +: 2])
         2'h0:    hlimit = DLCC_HCNT_W'(HREF0_CYC - 1);
         2'h1:    hlimit = DLCC_HCNT_W'(HREF1_CYC - 1);
         2'h2:    hlimit = DLCC_HCNT_W'(HREF2_CYC - 1);
         default: hlimit = DLCC_HCNT_W'(HREF3_CYC - 1);
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         hcnt_reg      <= '0;
         holdover_tick <= 1'b0;
      end else if (hcnt_reg >= hlimit) begin
         hcnt_reg      <= '0;
         holdover_tick <= 1'b1;
      end else begin
         hcnt_reg      <= hcnt_reg + 1'b1;
         holdover_tick <= 1'b0;
      end
   end

   // Checks
   sequence s_wr_ctrl1;
      wr_en && addr == DLCC_CTRL1_OFS;
   endsequence

   sequence s_rd_ctrl1;
      rd_en && !wr_en && addr == DLCC_CTRL1_OFS;
   endsequence

   property p_requal_factor;
      @(posedge mclk) disable iff (srst)
      qual_reg[5:4] == 2'h3 |=> loop_cfg.requalify_factor == 6'h20;
   endproperty
   a_requal_factor: assert property (p_requal_factor)
      else $error("requalify factor not 32 for code 11");

   property p_drop_code;
      @(posedge mclk) disable iff (srst)
      1'b1 |=> loop_cfg.drop_delay_code == $past(qual_reg[3:0]);
   endproperty
   a_drop_code: assert property (p_drop_code)
      else $error("drop delay code does not follow register");

   property p_buildout;
      @(posedge mclk) disable iff (srst)
      ref_switch && !ctrl0_reg[0] |=> buildout_pulse && !realign_pulse;
   endproperty
   a_buildout: assert property (p_buildout)
      else $error("switch with realign off did not build out");

   property p_realign;
      @(posedge mclk) disable iff (srst)
      ref_switch && ctrl0_reg[0] |=> realign_pulse && !buildout_pulse;
   endproperty
   a_realign: assert property (p_realign)
      else $error("switch with realign on did not realign");

   property p_strap_reset;
      @(posedge mclk)
      srst ##1 !srst |-> ctrl0_reg[0] == !$past(buildout_strap_pin && !secondary_role_pin);
   endproperty
   a_strap_reset: assert property (p_strap_reset)
      else $error("realign reset value does not follow straps");

   property p_bw_limit;
      @(posedge mclk) disable iff (srst)
      ctrl0_reg[3:1] == DLCC_BW_890HZ && ref_is_8khz && !ref_is_2khz
      |=> loop_cfg.loop_width == DLCC_LW_56HZ;
   endproperty
   a_bw_limit: assert property (p_bw_limit)
      else $error("890 Hz not limited to 56 Hz for 8 kHz reference");

   property p_bw_reset;
      @(posedge mclk)
      srst ##1 !srst |-> ctrl0_reg[3:1] == ($past(secondary_role_pin) ? 3'h5 : 3'h6);
   endproperty
   a_bw_reset: assert property (p_bw_reset)
      else $error("bandwidth reset value wrong");

   property p_ext_width;
      @(posedge mclk) disable iff (srst)
      ctrl0_reg[3:1] == DLCC_BW_EXT && ctrl0_reg[7:6] == 2'h2
      |=> loop_cfg.loop_width == DLCC_LW_EXT3P0;
   endproperty
   a_ext_width: assert property (p_ext_width)
      else $error("extended width 3.0 not applied");

   property p_reset_fixed;
      @(posedge mclk)
      srst ##1 !srst |-> ctrl0_reg[7:4] == 4'h7 && ctrl1_reg[5:0] == 6'h04;
   endproperty
   a_reset_fixed: assert property (p_reset_fixed)
      else $error("fixed reset values wrong");

   property p_filt_reset;
      @(posedge mclk)
      srst ##1 !srst |-> ctrl1_reg[7:6] == ($past(secondary_role_pin) ? 2'h1 : 2'h0);
   endproperty
   a_filt_reset: assert property (p_filt_reset)
      else $error("post filter reset value wrong");

   property p_tick_gap;
      @(posedge mclk) disable iff (srst)
      holdover_tick |=> !holdover_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("holdover ticks back to back");

   property p_readback;
      @(posedge mclk) disable iff (srst)
      s_wr_ctrl1 ##1 s_rd_ctrl1 |=> rd_data == $past(wr_data, 2);
   endproperty
   a_readback: assert property (p_readback)
      else $error("control 1 read back differs from write");

   property p_qual_write;
      @(posedge mclk) disable iff (srst)
      wr_en && addr == DLCC_QUAL_OFS |=> qual_reg == $past(wr_data);
   endproperty
   a_qual_write: assert property (p_qual_write)
      else $error("qualification register did not take the write");

   property p_rd_idle;
      @(posedge mclk) disable iff (srst)
      !rd_en |=> rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data stood longer than one cycle");

   property p_bw_2k;
      @(posedge mclk) disable iff (srst)
      (ctrl0_reg[3:1] == DLCC_BW_28HZ || ctrl0_reg[3:1] == DLCC_BW_890HZ) && ref_is_2khz
      |=> loop_cfg.loop_width == DLCC_LW_14HZ;
   endproperty
   a_bw_2k: assert property (p_bw_2k)
      else $error("bandwidth not limited to 14 Hz for 2 kHz reference");

   property p_fast_lock;
      @(posedge mclk) disable iff (srst)
      ctrl0_reg[3:1] == 3'h6 |=> loop_cfg.loop_width == DLCC_LW_FAST7;
   endproperty
   a_fast_lock: assert property (p_fast_lock)
      else $error("fast lock code did not select 7 Hz");

   property p_ext_ignored;
      @(posedge mclk) disable iff (srst)
      ctrl0_reg[3:1] != DLCC_BW_EXT
      |=> !(loop_cfg.loop_width inside {DLCC_LW_EXT0P3, DLCC_LW_EXT1P0, DLCC_LW_EXT3P0});
   endproperty
   a_ext_ignored: assert property (p_ext_ignored)
      else $error("extended width used without code 111");

   property p_ext_narrow;
      @(posedge mclk) disable iff (srst)
      ctrl0_reg[3:1] == DLCC_BW_EXT && ctrl0_reg[7:6] == 2'h0
      |=> loop_cfg.loop_width == DLCC_LW_EXT0P3;
   endproperty
   a_ext_narrow: assert property (p_ext_narrow)
      else $error("extended width 0.3 not applied");

   property p_slew_follow;
      @(posedge mclk) disable iff (srst)
      1'b1 |=> loop_cfg.phase_slew_cap == $past(ctrl0_reg[5:4]);
   endproperty
   a_slew_follow: assert property (p_slew_follow)
      else $error("phase slew cap does not follow register");

   property p_ctrl1_fields;
      @(posedge mclk) disable iff (srst)
      1'b1 |=> loop_cfg.revertive == $past(ctrl1_reg[0])
               && loop_cfg.holdover_refresh == $past(ctrl1_reg[5:4])
               && loop_cfg.holdover_post_filter == $past(ctrl1_reg[7:6]);
   endproperty
   a_ctrl1_fields: assert property (p_ctrl1_fields)
      else $error("control 1 fields do not follow register");

endmodule

// File: hdl/dlcc_pkg.sv
// Package: register map, field layout, reset values and timing for the loop config bank
package dlcc_pkg;

   // Register offsets
   localparam logic [7:0] DLCC_QUAL_OFS  = 8'h1c;
   localparam logic [7:0] DLCC_CTRL0_OFS = 8'h1d;
   localparam logic [7:0] DLCC_CTRL1_OFS = 8'h1e;

   // Field positions (low bit of each field)
   localparam int DLCC_DROP_LSB    = 0;
   localparam int DLCC_REQUAL_LSB  = 4;
   localparam int DLCC_REALIGN_BIT = 0;
   localparam int DLCC_BW_LSB      = 1;
   localparam int DLCC_SLEW_LSB    = 4;
   localparam int DLCC_S3E_LSB     = 6;
   localparam int DLCC_REVERT_BIT  = 0;
   localparam int DLCC_HREF_LSB    = 4;
   localparam int DLCC_PFILT_LSB   = 6;

   // Reset values
   localparam logic [7:0] DLCC_QUAL_RST      = 8'h1a;
   localparam logic [7:0] DLCC_CTRL1_FIX_RST = 8'h04;
   localparam logic [1:0] DLCC_SLEW_RST      = 2'h3;
   localparam logic [1:0] DLCC_S3E_RST       = 2'h1;
   localparam logic [2:0] DLCC_BW_RST_PRI    = 3'h6;
   localparam logic [2:0] DLCC_BW_RST_SEC    = 3'h5;
   localparam logic [1:0] DLCC_PFILT_RST_PRI = 2'h0;
   localparam logic [1:0] DLCC_PFILT_RST_SEC = 2'h1;

   // Bandwidth codes of the main field
   localparam logic [2:0] DLCC_BW_28HZ  = 3'h4;
   localparam logic [2:0] DLCC_BW_890HZ = 3'h5;
   localparam logic [2:0] DLCC_BW_EXT   = 3'h7;

   // Holdover refresh intervals and their cycle counts at the core clock
   localparam longint DLCC_CLK_KHZ   = 200000;
   localparam longint DLCC_HREF0_MS  = 26;
   localparam longint DLCC_HREF1_MS  = 1000;
   localparam longint DLCC_HREF2_MS  = 10000;
   localparam longint DLCC_HREF3_MS  = 60000;
   localparam longint DLCC_HREF0_CYC = DLCC_HREF0_MS * DLCC_CLK_KHZ;
   localparam longint DLCC_HREF1_CYC = DLCC_HREF1_MS * DLCC_CLK_KHZ;
   localparam longint DLCC_HREF2_CYC = DLCC_HREF2_MS * DLCC_CLK_KHZ;
   localparam longint DLCC_HREF3_CYC = DLCC_HREF3_MS * DLCC_CLK_KHZ;
   localparam int     DLCC_HCNT_W    = 34;

   // Effective loop bandwidth as seen by the loop filter
   typedef enum logic [3:0] {
      DLCC_LW_0P1HZ  = 4'h0,
      DLCC_LW_1P7HZ  = 4'h1,
      DLCC_LW_3P5HZ  = 4'h2,
      DLCC_LW_14HZ   = 4'h3,
      DLCC_LW_28HZ   = 4'h4,
      DLCC_LW_890HZ  = 4'h5,
      DLCC_LW_FAST7  = 4'h6,
      DLCC_LW_56HZ   = 4'h7,
      DLCC_LW_EXT0P3 = 4'h8,
      DLCC_LW_EXT1P0 = 4'h9,
      DLCC_LW_EXT3P0 = 4'ha
   } dlcc_width_t;

   // Decoded configuration handed to the loop, monitor and switch logic
   typedef struct packed {
      logic [3:0]  drop_delay_code;
      logic [5:0]  requalify_factor;
      logic        realign_on_switch;
      dlcc_width_t loop_width;
      logic [1:0]  phase_slew_cap;
      logic        revertive;
      logic [1:0]  holdover_refresh;
      logic [1:0]  holdover_post_filter;
   } dlcc_cfg_t;

endpackage

// File: testbench/tb.sv
// Self-checking bench for the loop control configuration bank
module tb import dlcc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // Short refresh intervals keep the run brief; expectations derive from these
   localparam int HCYC [4] = '{8, 16, 32, 64};
   localparam int FAC [4]  = '{2, 4, 16, 32};

   logic       mclk;
   logic       srst;
   logic       strap;
   logic       sec;
   logic [7:0] addr;
   logic [7:0] wr_data;
   logic       wr_en;
   logic       rd_en;
   logic [7:0] rd_data;
   logic       r2k;
   logic       r8k;
   logic       ref_switch;
   logic       buildout_pulse;
   logic       realign_pulse;
   logic       holdover_tick;
   dlcc_cfg_t  loop_cfg;
   int         fail_count;
   int         checks_done;
   int         cycles = 0;
   int         gap;

   dlcc_loop_config #(
      .HREF0_CYC(HCYC[0]),
      .HREF1_CYC(HCYC[1]),
      .HREF2_CYC(HCYC[2]),
      .HREF3_CYC(HCYC[3])
   ) i_dut (
      .mclk              (mclk),
      .srst              (srst),
      .buildout_strap_pin(strap),
      .secondary_role_pin(sec),
      .addr              (addr),
      .wr_data           (wr_data),
      .wr_en             (wr_en),
      .rd_en             (rd_en),
      .rd_data           (rd_data),
      .ref_is_2khz       (r2k),
      .ref_is_8khz       (r8k),
      .ref_switch        (ref_switch),
      .buildout_pulse    (buildout_pulse),
      .realign_pulse     (realign_pulse),
      .holdover_tick     (holdover_tick),
      .loop_cfg          (loop_cfg)
   );

   initial begin
      mclk = 1'h0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic results;
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic do_reset(input logic st, input logic sc);
      @(posedge mclk) begin
         srst  <= 1'h1;
         strap <= st;
         sec   <= sc;
      end
      repeat (6) @(posedge mclk);
      srst <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) begin
         wr_en   <= 1'h1;
         addr    <= a;
         wr_data <= d;
      end
      @(posedge mclk) wr_en <= 1'h0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk) begin
         rd_en <= 1'h1;
         addr  <= a;
      end
      @(posedge mclk) rd_en <= 1'h0;
      #1 chk(rd_data, exp);
   endtask

   // Write then read the same register with no idle cycle between strobes
   task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) begin
         wr_en   <= 1'h1;
         addr    <= a;
         wr_data <= d;
      end
      @(posedge mclk) begin
         wr_en <= 1'h0;
         rd_en <= 1'h1;
      end
      @(posedge mclk) rd_en <= 1'h0;
      #1 chk(rd_data, d);
   endtask

   // Register update lands on one edge, the decoded copy on the next
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic tick_gap(output int g);
      int n;
      n = 0;
      while (holdover_tick !== 1'h1 && n < 200) begin
         @(posedge mclk) #1;
         n++;
      end
      g = 0;
      do begin
         @(posedge mclk) #1;
         g++;
      end while (holdover_tick !== 1'h1 && g < 200);
   endtask

   function automatic logic [3:0] exp_w(int c, int f);
      case (c)
         4: return (f == 1) ? 4'h3 : 4'h4;
         5: return (f == 1) ? 4'h3 : (f == 2) ? 4'h7 : 4'h5;
         7: return 4'h8 + 4'(f);
         default: return 4'(c);
      endcase
   endfunction

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end

   initial begin
      {srst, strap, sec, wr_en, rd_en, r2k, r8k, ref_switch} = 8'h80;
      addr = 8'h0;
      wr_data = 8'h0;
      fail_count = 0;
      checks_done = 0;
      // Every strap combination, since three reset values hang on them
      for (int i = 0; i < 4; i++) begin
         do_reset(i[0], i[1]);
         rd_chk(DLCC_QUAL_OFS, 8'h1a);
         rd_chk(DLCC_CTRL0_OFS, {4'h7, i[1] ? 3'h5 : 3'h6, !(i[0] && !i[1])});
         rd_chk(DLCC_CTRL1_OFS, {i[1] ? 2'h1 : 2'h0, 6'h04});
      end
      wr(DLCC_QUAL_OFS, 8'h25);
      rd_chk(DLCC_QUAL_OFS, 8'h25);
      @(posedge mclk) #1 chk(rd_data, 8'h0);
      wr(8'h1f, 8'hff);
      rd_chk(8'h1f, 8'h0);
      rd_chk(DLCC_QUAL_OFS, 8'h25);
      for (int q = 0; q < 4; q++) begin
         wr(DLCC_QUAL_OFS, {2'h0, 2'(q), 4'hf - 4'(q)});
         settle();
         chk(loop_cfg.requalify_factor, FAC[q]);
         chk(loop_cfg.drop_delay_code, 15 - q);
      end
      // Slew and extended width ride along with the reference rate index
      for (int c = 0; c < 8; c++) begin
         for (int f = 0; f < 3; f++) begin
            @(posedge mclk) begin
               r2k <= (f == 1);
               r8k <= (f == 2);
            end
            wr(DLCC_CTRL0_OFS, {2'(f), 2'(f), 3'(c), 1'h0});
            settle();
            chk(loop_cfg.loop_width, exp_w(c, f));
            chk(loop_cfg.phase_slew_cap, f);
            rd_chk(DLCC_CTRL0_OFS, {2'(f), 2'(f), 3'(c), 1'h0});
         end
      end
      @(posedge mclk) begin
         r2k <= 1'h0;
         r8k <= 1'h0;
      end
      for (int v = 0; v < 4; v++) begin
         wr_rd_chk(DLCC_CTRL1_OFS, {2'(v), 2'(v), 3'h2, v[0]});
         settle();
         chk(loop_cfg.revertive, v[0]);
         chk(loop_cfg.holdover_refresh, v);
         chk(loop_cfg.holdover_post_filter, v);
         tick_gap(gap);
         chk(gap, HCYC[v]);
      end
      // Two switches back to back must give two pulses of the chosen kind
      for (int b = 0; b < 2; b++) begin
         wr(DLCC_CTRL0_OFS, {4'h7, 3'h6, b[0]});
         settle();
         chk(loop_cfg.realign_on_switch, b);
         @(posedge mclk) ref_switch <= 1'h1;
         @(posedge mclk) #1 chk({realign_pulse, buildout_pulse}, b ? 2'h2 : 2'h1);
         @(posedge mclk) ref_switch <= 1'h0;
         #1 chk({realign_pulse, buildout_pulse}, b ? 2'h2 : 2'h1);
         @(posedge mclk) #1 chk({realign_pulse, buildout_pulse}, 2'h0);
      end
      results();
   end
endmodule
